//--- acqf_pkg.sv
// Constants, types and register map of the acquisition output word formatter
package acqf_pkg;

    localparam int ACQF_ADDR_W = 8;
    localparam int ACQF_DATA_W = 32;
    localparam int ACQF_RESULT_W = 12;
    localparam int ACQF_NIBBLE_W = 4;
    localparam int ACQF_WORD_W = 16;
    localparam int ACQF_COUNT_W = 16;

    // Register byte offsets
    localparam logic [7:0] ACQF_CFG_OFS = 8'h00;
    localparam logic [7:0] ACQF_WORD_OFS = 8'h04;
    localparam logic [7:0] ACQF_HELD_OFS = 8'h08;
    localparam logic [7:0] ACQF_STATUS_OFS = 8'h0c;
    localparam logic [7:0] ACQF_COUNT_OFS = 8'h10;

    // Configuration register field positions
    localparam int ACQF_CFG_TYPE_LSB = 0;
    localparam int ACQF_CFG_BIPOLAR_BIT = 3;
    localparam int ACQF_CFG_TWOS_BIT = 4;

    // Status register field positions
    localparam int ACQF_STAT_BUSY_BIT = 0;
    localparam int ACQF_STAT_OE_BIT = 1;
    localparam int ACQF_STAT_GATE_LSB = 4;

    // Write and read responses
    localparam logic [1:0] ACQF_RESP_OKAY = 2'h0;
    localparam logic [1:0] ACQF_RESP_SLVERR = 2'h2;

    // Five output types of the upper nibble
    typedef enum logic [2:0] {
        ACQF_TYPE_NEXT = 3'h0,
        ACQF_TYPE_PRESENT = 3'h1,
        ACQF_TYPE_SIGN_BIN = 3'h2,
        ACQF_TYPE_SIGN_TWOS = 3'h3,
        ACQF_TYPE_ZEROS = 3'h4
    } acqf_out_type_t;

    typedef struct packed {
        logic twos;
        logic bipolar;
        acqf_out_type_t out_type;
    } acqf_cfg_t;

    typedef struct packed {
        logic [ACQF_NIBBLE_W-1:0] upper;
        logic [ACQF_RESULT_W-1:0] result;
    } acqf_word_t;

    localparam acqf_cfg_t ACQF_CFG_RST = '{1'b0, 1'b0, ACQF_TYPE_ZEROS};

    // Bus channel states
    typedef enum logic {
        ACQF_CH_IDLE = 1'b0,
        ACQF_CH_RESP = 1'b1
    } acqf_ch_state_t;

endpackage

//--- acqf_busy_latch.sv
// Busy edge detection with result and channel address capture
`timescale 1ns/1ps
`default_nettype none
module acqf_busy_latch
    import acqf_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic busy_in,
    input wire logic [ACQF_RESULT_W-1:0] result_in,
    input wire logic [ACQF_NIBBLE_W-1:0] next_chan_in,
    input wire logic [ACQF_NIBBLE_W-1:0] present_chan_in,
    output logic busy_out,
    output logic [ACQF_RESULT_W-1:0] result_out,
    output logic [ACQF_NIBBLE_W-1:0] next_held_out,
    output logic [ACQF_NIBBLE_W-1:0] present_held_out,
    output logic [ACQF_COUNT_W-1:0] conv_count_out
);

    logic busy_r;
    logic busy_nxt;
    logic [ACQF_RESULT_W-1:0] result_r;
    logic [ACQF_RESULT_W-1:0] result_nxt;
    logic [ACQF_NIBBLE_W-1:0] next_r;
    logic [ACQF_NIBBLE_W-1:0] next_nxt;
    logic [ACQF_NIBBLE_W-1:0] present_r;
    logic [ACQF_NIBBLE_W-1:0] present_nxt;
    logic [ACQF_COUNT_W-1:0] count_r;
    logic [ACQF_COUNT_W-1:0] count_nxt;
    logic busy_rise;
    logic busy_fall;

    assign busy_rise = busy_in & ~busy_r;
    assign busy_fall = ~busy_in & busy_r;

    // Each value holds until its own edge comes round again
    always_comb begin
        busy_nxt = busy_in;
        result_nxt = result_r;
        next_nxt = next_r;
        present_nxt = present_r;
        count_nxt = count_r;
        if (busy_fall) begin
            result_nxt = result_in; // Result settled once busy drops
            next_nxt = next_chan_in;
            count_nxt = count_r + 1'b1;
        end
        if (busy_rise) begin
            present_nxt = present_chan_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            busy_r <= 1'b0;
            result_r <= '0;
            next_r <= '0;
            present_r <= '0;
            count_r <= '0;
        end else begin
            busy_r <= busy_nxt;
            result_r <= result_nxt;
            next_r <= next_nxt;
            present_r <= present_nxt;
            count_r <= count_nxt;
        end
    end

    assign busy_out = busy_r;
    assign result_out = result_r;
    assign next_held_out = next_r;
    assign present_held_out = present_r;
    assign conv_count_out = count_r;

endmodule
`default_nettype wire

//--- acqf_formatter.sv
// Output word formatter top with nibble read gates and register slave
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module acqf_formatter
    import acqf_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    // Register bus, write address channel
    input wire logic [ACQF_ADDR_W-1:0] S_AXI_AWADDR_IN,
    input wire logic [2:0] S_AXI_AWPROT_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    // Write data channel
    input wire logic [ACQF_DATA_W-1:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    // Write response channel
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // Read address channel
    input wire logic [ACQF_ADDR_W-1:0] S_AXI_ARADDR_IN,
    input wire logic [2:0] S_AXI_ARPROT_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    // Read data channel
    output logic [ACQF_DATA_W-1:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // Converter side
    input wire logic CONV_BUSY_IN,
    input wire logic [ACQF_RESULT_W-1:0] CONV_RESULT_IN,
    input wire logic [ACQF_NIBBLE_W-1:0] NEXT_CHANNEL_IN,
    input wire logic [ACQF_NIBBLE_W-1:0] PRESENT_CHANNEL_IN,
    // Host side read gates, bit 0 is the first gate
    input wire logic [3:0] READ_GATE_N_IN,
    output logic [ACQF_NIBBLE_W-1:0] DATA_NIBBLE_OUT,
    output logic DATA_NIBBLE_OE_OUT,
    output logic [ACQF_WORD_W-1:0] DATA_WORD_OUT,
    output logic [ACQF_NIBBLE_W-1:0] HELD_CHANNEL_INDEX_OUT
);

    // Captured converter state
    logic busy_q;
    logic [ACQF_RESULT_W-1:0] lat_result;
    logic [ACQF_NIBBLE_W-1:0] next_held;
    logic [ACQF_NIBBLE_W-1:0] present_held;
    logic [ACQF_COUNT_W-1:0] conv_count;

    // Configuration and formatted outputs
    acqf_cfg_t cfg_r;
    acqf_cfg_t cfg_nxt;
    acqf_word_t word_nxt;
    logic [ACQF_WORD_W-1:0] word_r;
    logic [ACQF_NIBBLE_W-1:0] nibble_r;
    logic [ACQF_NIBBLE_W-1:0] nibble_nxt;
    logic oe_r;
    logic oe_nxt;
    logic [ACQF_NIBBLE_W-1:0] held_r;
    logic [ACQF_NIBBLE_W-1:0] held_nxt;

    // Write side state
    acqf_ch_state_t wr_state_r;
    acqf_ch_state_t wr_state_nxt;
    logic aw_held_r;
    logic aw_held_nxt;
    logic w_held_r;
    logic w_held_nxt;
    logic [ACQF_ADDR_W-1:0] awaddr_r;
    logic [ACQF_ADDR_W-1:0] awaddr_nxt;
    logic [ACQF_DATA_W-1:0] wdata_r;
    logic [ACQF_DATA_W-1:0] wdata_nxt;
    logic [3:0] wstrb_r;
    logic [3:0] wstrb_nxt;
    logic awready_r;
    logic awready_nxt;
    logic wready_r;
    logic wready_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;

    // Read side state
    acqf_ch_state_t rd_state_r;
    acqf_ch_state_t rd_state_nxt;
    logic arready_r;
    logic arready_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [ACQF_DATA_W-1:0] rdata_r;
    logic [ACQF_DATA_W-1:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;

    logic [ACQF_DATA_W-1:0] rd_value;
    logic rd_hit;
    logic [ACQF_RESULT_W-1:0] result_fmt;

    acqf_busy_latch u_busy_latch (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN),
        .busy_in(CONV_BUSY_IN),
        .result_in(CONV_RESULT_IN),
        .next_chan_in(NEXT_CHANNEL_IN),
        .present_chan_in(PRESENT_CHANNEL_IN),
        .busy_out(busy_q),
        .result_out(lat_result),
        .next_held_out(next_held),
        .present_held_out(present_held),
        .conv_count_out(conv_count)
    );

    // Word assembly; the converter code already comes as straight or
    // offset binary, so only two's complement needs a change
    always_comb begin
        result_fmt = lat_result;
        if (cfg_r.bipolar && cfg_r.twos) begin
            result_fmt[ACQF_RESULT_W-1] = ~lat_result[ACQF_RESULT_W-1];
        end
        word_nxt.result = result_fmt;
        unique case (cfg_r.out_type)
            ACQF_TYPE_NEXT: begin
                word_nxt.upper = next_held;
            end
            ACQF_TYPE_PRESENT: begin
                word_nxt.upper = present_held;
            end
            ACQF_TYPE_SIGN_BIN: begin
                word_nxt.upper = {4{lat_result[ACQF_RESULT_W-1]}};
            end
            ACQF_TYPE_SIGN_TWOS: begin
                word_nxt.upper = {4{result_fmt[ACQF_RESULT_W-1]}};
            end
            ACQF_TYPE_ZEROS: begin
                word_nxt.upper = '0;
            end
            default: begin
                word_nxt.upper = '0;
            end
        endcase
        // Held address output is the next address in the next type and the present address in every other type
        if (cfg_r.out_type == ACQF_TYPE_NEXT) begin
            held_nxt = next_held;
        end else begin
            held_nxt = present_held;
        end
    end

    // Read gates; if the host lowers several, the lowest numbered wins
    // rather than letting nibbles fight on the shared lines
    always_comb begin
        nibble_nxt = '0;
        oe_nxt = ~&READ_GATE_N_IN;
        if (!READ_GATE_N_IN[0]) begin
            nibble_nxt = word_nxt.result[11:8];
        end else if (!READ_GATE_N_IN[1]) begin
            nibble_nxt = word_nxt.result[7:4];
        end else if (!READ_GATE_N_IN[2]) begin
            nibble_nxt = word_nxt.result[3:0];
        end else if (!READ_GATE_N_IN[3]) begin
            nibble_nxt = word_nxt.upper;
        end
    end

    // Write channel: address and data taken in either order
    always_comb begin
        wr_state_nxt = wr_state_r;
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        cfg_nxt = cfg_r;
        if (S_AXI_AWVALID_IN && awready_r) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt = S_AXI_AWADDR_IN;
        end
        if (S_AXI_WVALID_IN && wready_r) begin
            w_held_nxt = 1'b1;
            wdata_nxt = S_AXI_WDATA_IN;
            wstrb_nxt = S_AXI_WSTRB_IN;
        end
        unique case (wr_state_r)
            ACQF_CH_IDLE: begin
                if (aw_held_r && w_held_r) begin
                    aw_held_nxt = 1'b0;
                    w_held_nxt = 1'b0;
                    bvalid_nxt = 1'b1;
                    wr_state_nxt = ACQF_CH_RESP;
                    if (awaddr_r[7:2] == ACQF_CFG_OFS[7:2]) begin
                        bresp_nxt = ACQF_RESP_OKAY;
                        if (wstrb_r[0]) begin
                            cfg_nxt.out_type = acqf_out_type_t'(
                                wdata_r[ACQF_CFG_TYPE_LSB +: 3]);
                            cfg_nxt.bipolar = wdata_r[ACQF_CFG_BIPOLAR_BIT];
                            cfg_nxt.twos = wdata_r[ACQF_CFG_TWOS_BIT];
                        end
                    end else if (awaddr_r[7:2] == ACQF_WORD_OFS[7:2] ||
                                 awaddr_r[7:2] == ACQF_HELD_OFS[7:2] ||
                                 awaddr_r[7:2] == ACQF_STATUS_OFS[7:2] ||
                                 awaddr_r[7:2] == ACQF_COUNT_OFS[7:2]) begin
                        bresp_nxt = ACQF_RESP_OKAY; // Read-only, ignored
                    end else begin
                        bresp_nxt = ACQF_RESP_SLVERR;
                    end
                end
            end
            ACQF_CH_RESP: begin
                if (S_AXI_BREADY_IN) begin
                    bvalid_nxt = 1'b0;
                    wr_state_nxt = ACQF_CH_IDLE;
                end
            end
        endcase
        // Ready drops while a half is held, giving one write in flight
        awready_nxt = ~aw_held_nxt & (wr_state_nxt == ACQF_CH_IDLE);
        wready_nxt = ~w_held_nxt & (wr_state_nxt == ACQF_CH_IDLE);
    end

    // Read decode
    always_comb begin
        rd_value = '0;
        rd_hit = 1'b1;
        unique case (S_AXI_ARADDR_IN[7:2])
            ACQF_CFG_OFS[7:2]: begin
                rd_value[ACQF_CFG_TYPE_LSB +: 3] = cfg_r.out_type;
                rd_value[ACQF_CFG_BIPOLAR_BIT] = cfg_r.bipolar;
                rd_value[ACQF_CFG_TWOS_BIT] = cfg_r.twos;
            end
            ACQF_WORD_OFS[7:2]: begin
                rd_value[ACQF_WORD_W-1:0] = word_r;
            end
            ACQF_HELD_OFS[7:2]: begin
                rd_value[ACQF_NIBBLE_W-1:0] = held_r;
            end
            ACQF_STATUS_OFS[7:2]: begin
                rd_value[ACQF_STAT_BUSY_BIT] = busy_q;
                rd_value[ACQF_STAT_OE_BIT] = oe_r;
                rd_value[ACQF_STAT_GATE_LSB +: 4] = READ_GATE_N_IN;
            end
            ACQF_COUNT_OFS[7:2]: begin
                rd_value[ACQF_COUNT_W-1:0] = conv_count;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel: one read in flight, data one cycle after address
    always_comb begin
        rd_state_nxt = rd_state_r;
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        unique case (rd_state_r)
            ACQF_CH_IDLE: begin
                if (S_AXI_ARVALID_IN && arready_r) begin
                    arready_nxt = 1'b0;
                    rvalid_nxt = 1'b1;
                    rdata_nxt = rd_value;
                    rresp_nxt = rd_hit ? ACQF_RESP_OKAY : ACQF_RESP_SLVERR;
                    rd_state_nxt = ACQF_CH_RESP;
                end
            end
            ACQF_CH_RESP: begin
                if (S_AXI_RREADY_IN) begin
                    rvalid_nxt = 1'b0;
                    arready_nxt = 1'b1;
                    rd_state_nxt = ACQF_CH_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            cfg_r <= ACQF_CFG_RST;
            word_r <= '0;
            nibble_r <= '0;
            oe_r <= 1'b0;
            held_r <= '0;
            wr_state_r <= ACQF_CH_IDLE;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= ACQF_RESP_OKAY;
            rd_state_r <= ACQF_CH_IDLE;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= ACQF_RESP_OKAY;
        end else begin
            cfg_r <= cfg_nxt;
            word_r <= word_nxt;
            nibble_r <= nibble_nxt;
            oe_r <= oe_nxt;
            held_r <= held_nxt;
            wr_state_r <= wr_state_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rd_state_r <= rd_state_nxt;
            arready_r <= (rd_state_r == ACQF_CH_IDLE && !arready_r &&
                          !rvalid_r) ? 1'b1 : arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // All outputs straight from flops
    assign S_AXI_AWREADY_OUT = awready_r;
    assign S_AXI_WREADY_OUT = wready_r;
    assign S_AXI_BVALID_OUT = bvalid_r;
    assign S_AXI_BRESP_OUT = bresp_r;
    assign S_AXI_ARREADY_OUT = arready_r;
    assign S_AXI_RVALID_OUT = rvalid_r;
    assign S_AXI_RDATA_OUT = rdata_r;
    assign S_AXI_RRESP_OUT = rresp_r;
    assign DATA_NIBBLE_OUT = nibble_r;
    assign DATA_NIBBLE_OE_OUT = oe_r;
    assign DATA_WORD_OUT = word_r;
    assign HELD_CHANNEL_INDEX_OUT = held_r;

endmodule
`default_nettype wire

//--- acqf_formatter_monitor.sv
// Port-level checker for the acquisition output word formatter
`timescale 1ns/1ps
`default_nettype none
module acqf_monitor
    import acqf_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [ACQF_ADDR_W-1:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    input wire logic S_AXI_AWREADY_OUT,
    input wire logic [ACQF_DATA_W-1:0] S_AXI_WDATA_IN,
    input wire logic S_AXI_WVALID_IN,
    input wire logic S_AXI_WREADY_OUT,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic CONV_BUSY_IN,
    input wire logic [ACQF_RESULT_W-1:0] CONV_RESULT_IN,
    input wire logic [ACQF_NIBBLE_W-1:0] NEXT_CHANNEL_IN,
    input wire logic [ACQF_NIBBLE_W-1:0] PRESENT_CHANNEL_IN,
    input wire logic [3:0] READ_GATE_N_IN,
    input wire logic [ACQF_NIBBLE_W-1:0] DATA_NIBBLE_OUT,
    input wire logic DATA_NIBBLE_OE_OUT,
    input wire logic [ACQF_WORD_W-1:0] DATA_WORD_OUT,
    input wire logic [ACQF_NIBBLE_W-1:0] HELD_CHANNEL_INDEX_OUT
);
    logic [ACQF_ADDR_W-1:0] wa_r, wa_nxt;
    acqf_cfg_t wd_r, wd_nxt, cfg_r, cfg_nxt;
    logic flip;
    logic [3:0] up_exp;

    // Shadow of the config register; only a completed write counts
    always_comb begin
        wa_nxt = wa_r;
        wd_nxt = wd_r;
        cfg_nxt = cfg_r;
        if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) wa_nxt = S_AXI_AWADDR_IN;
        if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
            wd_nxt = acqf_cfg_t'(S_AXI_WDATA_IN[4:0]);
        if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN
            && wa_r[7:2] == ACQF_CFG_OFS[7:2]) cfg_nxt = wd_r;
        if (!RST_N_IN) cfg_nxt = ACQF_CFG_RST;
    end

    // Registers of the shadow
    always_ff @(posedge REF_CLK_IN) begin
        wa_r <= wa_nxt;
        wd_r <= wd_nxt;
        cfg_r <= cfg_nxt;
    end

    // Expected upper nibble; bit 11 of the word is already converted
    always_comb begin
        flip = cfg_r.bipolar & cfg_r.twos;
        case (cfg_r.out_type)
            ACQF_TYPE_NEXT, ACQF_TYPE_PRESENT: up_exp = HELD_CHANNEL_INDEX_OUT;
            ACQF_TYPE_SIGN_BIN: up_exp = {4{DATA_WORD_OUT[11] ^ flip}};
            ACQF_TYPE_SIGN_TWOS: up_exp = {4{DATA_WORD_OUT[11]}};
            default: up_exp = 4'h0;
        endcase
    end

    default clocking mon_cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    // Word held steady, so either reading of the nibble source agrees
    property gate_p(logic sel, logic [3:0] val);
        $past(RST_N_IN) && sel && $stable(DATA_WORD_OUT)
        |-> DATA_NIBBLE_OE_OUT && DATA_NIBBLE_OUT == val;
    endproperty

    gate_first_a: assert property (gate_p(!$past(READ_GATE_N_IN[0]),
        DATA_WORD_OUT[11:8])) else $error("first gate nibble wrong");
    gate_second_a: assert property (gate_p(
        $past(READ_GATE_N_IN[1:0]) == 2'h1, DATA_WORD_OUT[7:4]))
        else $error("second gate nibble wrong");
    gate_third_a: assert property (gate_p(
        $past(READ_GATE_N_IN[2:0]) == 3'h3, DATA_WORD_OUT[3:0]))
        else $error("third gate nibble wrong");
    gate_fourth_a: assert property (gate_p(
        $past(READ_GATE_N_IN) == 4'h7, DATA_WORD_OUT[15:12]))
        else $error("fourth gate nibble wrong");
    upper_type_a: assert property (
        DATA_WORD_OUT[15:12] == up_exp) else $error("upper bits wrong");
    result_code_a: assert property (
        $fell(CONV_BUSY_IN) |-> ##2 DATA_WORD_OUT[11:0]
        == ($past(CONV_RESULT_IN, 2) ^ {flip, 11'h000}))
        else $error("result code wrong");
    next_addr_a: assert property (
        cfg_r.out_type == ACQF_TYPE_NEXT && $fell(CONV_BUSY_IN) |-> ##2
        HELD_CHANNEL_INDEX_OUT == $past(NEXT_CHANNEL_IN, 2))
        else $error("next address wrong");
    present_addr_a: assert property (
        cfg_r.out_type == ACQF_TYPE_PRESENT && $rose(CONV_BUSY_IN) |-> ##2
        HELD_CHANNEL_INDEX_OUT == $past(PRESENT_CHANNEL_IN, 2))
        else $error("present address wrong");
    held_stable_a: assert property (
        $past(RST_N_IN) && $past(CONV_BUSY_IN) == $past(CONV_BUSY_IN, 2)
        |=> $stable(HELD_CHANNEL_INDEX_OUT) || $changed(cfg_r))
        else $error("held address moved");

    cover property ($fell(CONV_BUSY_IN) && cfg_r.out_type == ACQF_TYPE_NEXT);
    cover property (!$past(READ_GATE_N_IN[0]) && !$past(READ_GATE_N_IN[3]));
    cover property (cfg_r.out_type == ACQF_TYPE_SIGN_TWOS && flip);
endmodule

bind acqf_formatter acqf_monitor u_mon (.*);
`default_nettype wire

//--- acqf_host_model.sv
// Host computer model reading the output word one nibble at a time
`timescale 1ns/1ps
`default_nettype none
module acqf_host_model
    import acqf_pkg::*;
(
    input wire logic clk_in,
    input wire logic [ACQF_NIBBLE_W-1:0] nibble_in,
    input wire logic oe_in,
    output logic [3:0] gate_n_out
);
    initial gate_n_out = 4'hf;

    // Gates held low for two edges so the registered nibble has settled
    task automatic gate_read(input logic [3:0] g_n, output logic [3:0] val,
                             output logic en);
        @(posedge clk_in);
        gate_n_out <= g_n;
        @(posedge clk_in);
        @(posedge clk_in);
        val = nibble_in;
        en = oe_in;
        gate_n_out <= 4'hf;
    endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the acquisition output word formatter
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import acqf_pkg::*;
;
    logic clk, rst_n, busy, awvalid, wvalid, bready, arvalid, rready, oe, o;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, x, d;
    logic [1:0] bresp, rresp, rs;
    logic [11:0] result;
    logic [3:0] nxt_ch, pre_ch, gate_n, nib, held, v;
    logic [15:0] word, last_w;
    logic [4:0] cfg;
    logic [31:0] seed = 32'h823ac9e9;
    logic [31:0] cyc = 32'h0;
    logic [11:0] bnd [3] = '{12'h000, 12'h800, 12'hfff};
    logic [3:0] pri_m [3] = '{4'h0, 4'h5, 4'h3};
    int n_errors, tests_run, n_conv;
    logic [15:0] exp_q [$];

    acqf_formatter DUT (
        .REF_CLK_IN(clk), .RST_N_IN(rst_n),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWPROT_IN(3'h0),
        .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf),
        .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
        .S_AXI_ARPROT_IN(3'h0), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready), .CONV_BUSY_IN(busy),
        .CONV_RESULT_IN(result), .NEXT_CHANNEL_IN(nxt_ch),
        .PRESENT_CHANNEL_IN(pre_ch), .READ_GATE_N_IN(gate_n),
        .DATA_NIBBLE_OUT(nib), .DATA_NIBBLE_OE_OUT(oe),
        .DATA_WORD_OUT(word), .HELD_CHANNEL_INDEX_OUT(held)
    );

    acqf_host_model u_host (.clk_in(clk), .nibble_in(nib), .oe_in(oe),
        .gate_n_out(gate_n));

    // Free-running clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cuts a hung run short; the full run needs far fewer cycles
    always @(posedge clk) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'h1388) begin
            n_errors++;
            final_report();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Each channel is released at the edge that takes it
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat);
        logic done;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= dat;
        {awvalid, wvalid, bready} <= 3'h7;
        while (!done) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] a);
        logic done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        while (!done) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                rs = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // One busy pulse; inputs are scrambled once captured
    task automatic convert(input logic [11:0] r, input logic [3:0] nx,
                           input logic [3:0] pr);
        logic [11:0] c;
        logic [3:0] up;
        @(posedge clk);
        busy <= 1'b1;
        pre_ch <= pr;
        repeat (3) @(posedge clk);
        {busy, result, nxt_ch} <= {1'b0, r, nx};
        @(posedge clk);
        x = rnd();
        {result, nxt_ch, pre_ch} <= x[19:0];
        repeat (3) @(posedge clk);
        c = r ^ ((cfg[3] & cfg[4]) ? 12'h800 : 12'h000);
        case (cfg[2:0])
            3'h0: up = nx;
            3'h1: up = pr;
            3'h2: up = {4{r[11]}};
            3'h3: up = {4{c[11]}};
            default: up = 4'h0;
        endcase
        exp_q.push_back({up, c});
        n_conv++;
        chk("held index", (cfg[2:0] == 3'h0) ? nx : pr, held);
    endtask

    // Word read through all four gates and through the register bus
    task automatic read_word();
        last_w = exp_q.pop_front();
        chk("word out", last_w, word);
        for (int g = 0; g < 4; g++) begin
            u_host.gate_read(~(4'h1 << g), v, o);
            chk("gated nibble", last_w[4*(g == 3 ? 3 : 2 - g) +: 4], v);
            chk("drive enable", 1'b1, o);
        end
        axi_rd(ACQF_WORD_OFS);
        chk("word reg", {16'h0, last_w}, d);
    endtask

    initial begin
        rst_n = 1'b0;
        {busy, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, result, nxt_ch, pre_ch} = 'h0;
        n_errors = 0;
        tests_run = 0;
        n_conv = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        axi_rd(ACQF_CFG_OFS);
        chk("cfg reset", 32'h4, d);
        axi_rd(8'h14);
        chk("unmapped read", 32'h0, d);
        chk("unmapped rresp", ACQF_RESP_SLVERR, rs);
        axi_wr(8'h14, 32'h1);
        chk("unmapped write", ACQF_RESP_SLVERR, rs);
        // Every output type plus one illegal code under every coding
        for (int t = 0; t < 6; t++) begin
            for (int c = 0; c < 3; c++) begin
                cfg = {c == 2, c > 0, t[2:0]};
                axi_wr(ACQF_CFG_OFS, {27'h0, cfg});
                axi_rd(ACQF_CFG_OFS);
                chk("cfg read", {27'h0, cfg}, d);
                for (int k = 0; k < 2; k++) begin
                    x = rnd();
                    if (k == 0) x[11:0] = bnd[(t + c) % 3];
                    convert(x[11:0], x[15:12], x[19:16]);
                    read_word();
                end
            end
        end
        // Several gates low at once: lowest numbered wins
        for (int i = 0; i < 3; i++) begin
            u_host.gate_read(pri_m[i], v, o);
            chk("gate priority", last_w[4*(2-i) +: 4], v);
        end
        axi_wr(ACQF_WORD_OFS, 32'h0);
        chk("ro write resp", ACQF_RESP_OKAY, rs);
        chk("word kept", last_w, word);
        axi_rd(ACQF_COUNT_OFS);
        chk("conversions", n_conv, d);
        final_report();
    end
endmodule
`default_nettype wire
